/* File: shift_flag_gen.sv */
// shift_flag_gen: condition codes for one shift/rotate result
// assumes result and carry-out are already formed by the caller
module shift_flag_gen
  import shift_rotate_pkg::*;
(
  input wire logic [WORD_W-1:0] result,
  input wire logic carry_out,
  input wire logic byte_mode,
  output logic [3:0] flags
);
  wire logic neg_bit = byte_mode ? result[BYTE_TOP] : result[WORD_TOP];
  wire logic zero_bit = byte_mode ? (result[BYTE_TOP:0] == WORD_ZERO[BYTE_TOP:0])
    : (result == WORD_ZERO);
  assign flags[CC_N] = neg_bit;
  assign flags[CC_Z] = zero_bit;
  assign flags[CC_V] = neg_bit ^ carry_out;
  assign flags[CC_C] = carry_out;
endmodule // shift_flag_gen

/* File: shift_rotate_pkg.sv */
// shift_rotate_pkg: opcode fields, widths and flag positions for the shift/rotate slice
// assumes the decoder hands over the 16-bit instruction word and a fetched operand
package shift_rotate_pkg;
  localparam int WORD_W = 16;
  localparam int OPC_W = 10;
  localparam int BYTE_SEL_BIT = 9;
  localparam int WORD_TOP = 15;
  localparam int BYTE_TOP = 7;
  localparam logic [8:0] OPC_ROTATE_RIGHT = 9'h030;
  localparam logic [8:0] OPC_ROTATE_LEFT = 9'h031;
  localparam logic [8:0] OPC_SHIFT_LEFT = 9'h033;
  localparam int CC_C = 0;
  localparam int CC_V = 1;
  localparam int CC_Z = 2;
  localparam int CC_N = 3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [3:0] CC_RESET = 4'h0;
  typedef enum logic [1:0] {OP_NONE, OP_SHL, OP_ROR, OP_ROL} shift_op_t;
endpackage

/* File: shift_rotate_unit.sv */
// shift_rotate_unit: one-cycle shift left and rotate left/right datapath with condition codes
// assumes instr/operand/psw_c are valid when start is high; results register on the next edge
//
// Contract
// - shift left moves bits up one place; bit 0 of result becomes zero.
// - shift left loads carry from the operand's old top bit.
// - shift left is signed doubling; overflow flags a doubled value that no longer fits.
// - after any operation overflow equals new negative xor new carry.
// - negative copies result top bit (bit 7 for bytes); zero set only when the result, or its low byte for bytes, is all zeros.
// - rotate right moves bits down, old carry enters top, old bit 0 to carry.
// - rotate right carry takes the operand's old least significant bit.
// - rotate right overflow uses negative and carry after the rotation.
// - rotate left moves bits up, old top bit to carry, old carry enters bit 0.
// - rotate left zero set only when every rotated bit is zero.
module shift_rotate_unit
  import shift_rotate_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [WORD_W-1:0] instr,
  input wire logic [WORD_W-1:0] operand,
  input wire logic psw_c,
  output logic done,
  output logic illegal,
  output logic [WORD_W-1:0] result,
  output logic [3:0] cc
);
  import shift_rotate_pkg::*;

  logic done_r;
  logic illegal_r;
  logic [WORD_W-1:0] result_r;
  logic [3:0] cc_r;
  logic [3:0] flags_nxt;

  wire logic byte_mode = instr[WORD_TOP];
  wire logic [8:0] opc_low = instr[BYTE_SEL_BIT+5:6];
  wire shift_op_t op = (opc_low == OPC_SHIFT_LEFT) ? OP_SHL
    : (opc_low == OPC_ROTATE_RIGHT) ? OP_ROR
    : (opc_low == OPC_ROTATE_LEFT) ? OP_ROL : OP_NONE;
  wire logic top_old = byte_mode ? operand[BYTE_TOP] : operand[WORD_TOP];

  // byte forms leave the high byte of the destination untouched
  wire logic [WORD_W-1:0] shl_w = {operand[WORD_TOP-1:0], 1'b0};
  wire logic [WORD_W-1:0] shl_b = {operand[WORD_TOP:BYTE_TOP+1], operand[BYTE_TOP-1:0], 1'b0};
  wire logic [WORD_W-1:0] ror_w = {psw_c, operand[WORD_TOP:1]};
  wire logic [WORD_W-1:0] ror_b = {operand[WORD_TOP:BYTE_TOP+1], psw_c, operand[BYTE_TOP:1]};
  wire logic [WORD_W-1:0] rol_w = {operand[WORD_TOP-1:0], psw_c};
  wire logic [WORD_W-1:0] rol_b = {operand[WORD_TOP:BYTE_TOP+1], operand[BYTE_TOP-1:0], psw_c};

  logic [WORD_W-1:0] res_nxt;
  logic carry_nxt;
  always_comb
  begin
    res_nxt = operand;
    carry_nxt = psw_c;
    unique case (op)
      OP_SHL:
      begin
        res_nxt = byte_mode ? shl_b : shl_w;
        carry_nxt = top_old;
      end
      OP_ROR:
      begin
        res_nxt = byte_mode ? ror_b : ror_w;
        carry_nxt = operand[0];
      end
      OP_ROL:
      begin
        res_nxt = byte_mode ? rol_b : rol_w;
        carry_nxt = top_old;
      end
      OP_NONE:
      begin
        res_nxt = operand;
        carry_nxt = psw_c;
      end
    endcase
  end

  shift_flag_gen u_flags (
    .result(res_nxt),
    .carry_out(carry_nxt),
    .byte_mode(byte_mode),
    .flags(flags_nxt)
  );

  // an unknown opcode raises illegal and keeps result and flags unchanged
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      result_r <= WORD_ZERO;
      cc_r <= CC_RESET;
    end
    else
    begin
      done_r <= start && (op != OP_NONE);
      illegal_r <= start && (op == OP_NONE);
      if (start && (op != OP_NONE))
      begin
        result_r <= res_nxt;
        cc_r <= flags_nxt;
      end
    end
  end

  assign done = done_r;
  assign illegal = illegal_r;
  assign result = result_r;
  assign cc = cc_r;

  // checks
  logic past_valid_r;
  always_ff @(posedge clk)
  begin
    if (srst)
      past_valid_r <= 1'b0;
    else
      past_valid_r <= 1'b1;
  end

  property p_shl_low_zero;
    @(posedge clk) disable iff (srst) start && op == OP_SHL |=> result[0] == 1'b0;
  endproperty
  a_shl_low_zero: assert property (p_shl_low_zero) else $error("shift left bit 0 not zero");

  property p_shl_carry;
    @(posedge clk) disable iff (srst)
      start && op == OP_SHL && !byte_mode |=> cc[CC_C] == $past(operand[WORD_TOP]);
  endproperty
  a_shl_carry: assert property (p_shl_carry) else $error("shift left carry wrong");

  property p_shl_ovf;
    @(posedge clk) disable iff (srst)
      start && op == OP_SHL && !byte_mode |=> cc[CC_V] == ($past(operand[WORD_TOP]) ^ $past(operand[WORD_TOP-1]));
  endproperty
  a_shl_ovf: assert property (p_shl_ovf) else $error("shift left overflow wrong");

  property p_v_xor;
    @(posedge clk) disable iff (srst) done |-> cc[CC_V] == (cc[CC_N] ^ cc[CC_C]);
  endproperty
  a_v_xor: assert property (p_v_xor) else $error("overflow not n xor c");

  property p_nz_word;
    @(posedge clk) disable iff (srst)
      done && !$past(byte_mode) |-> cc[CC_N] == result[WORD_TOP] && cc[CC_Z] == (result == WORD_ZERO);
  endproperty
  a_nz_word: assert property (p_nz_word) else $error("word n or z wrong");

  property p_ror_word;
    @(posedge clk) disable iff (srst)
      start && op == OP_ROR && !byte_mode |=> result[WORD_TOP] == $past(psw_c) && cc[CC_C] == $past(operand[0]);
  endproperty
  a_ror_word: assert property (p_ror_word) else $error("rotate right wrong");

  property p_rol_word;
    @(posedge clk) disable iff (srst)
      start && op == OP_ROL && !byte_mode |=> result[0] == $past(psw_c) && cc[CC_C] == $past(operand[WORD_TOP]);
  endproperty
  a_rol_word: assert property (p_rol_word) else $error("rotate left wrong");

  property p_byte_top;
    @(posedge clk) disable iff (srst)
      start && byte_mode && op != OP_NONE |=> cc[CC_N] == result[BYTE_TOP]
        && result[WORD_TOP:BYTE_TOP+1] == $past(operand[WORD_TOP:BYTE_TOP+1]);
  endproperty
  a_byte_top: assert property (p_byte_top) else $error("byte form wrong");

  property p_done_pulse;
    @(posedge clk) disable iff (srst) past_valid_r && !$past(start) |-> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done without start");

  // byte shift left and rotate left take their carry from bit 7, byte rotate right from bit 0, never from bit 15
  property p_shl_byte_carry;
    @(posedge clk) disable iff (srst)
      start && op == OP_SHL && byte_mode |=> cc[CC_C] == $past(operand[BYTE_TOP]) && result[0] == 1'b0;
  endproperty
  a_shl_byte_carry: assert property (p_shl_byte_carry) else $error("byte shift left carry wrong");

  property p_ror_byte;
    @(posedge clk) disable iff (srst)
      start && op == OP_ROR && byte_mode |=> result[BYTE_TOP] == $past(psw_c) && cc[CC_C] == $past(operand[0]);
  endproperty
  a_ror_byte: assert property (p_ror_byte) else $error("byte rotate right wrong");

  property p_rol_byte;
    @(posedge clk) disable iff (srst)
      start && op == OP_ROL && byte_mode |=> result[0] == $past(psw_c) && cc[CC_C] == $past(operand[BYTE_TOP]);
  endproperty
  a_rol_byte: assert property (p_rol_byte) else $error("byte rotate left wrong");

  property p_z_byte;
    @(posedge clk) disable iff (srst)
      done && $past(byte_mode) |-> cc[CC_Z] == (result[BYTE_TOP:0] == WORD_ZERO[BYTE_TOP:0]);
  endproperty
  a_z_byte: assert property (p_z_byte) else $error("byte zero flag wrong");

  // a refused opcode must leave the visible state alone
  property p_illegal_hold;
    @(posedge clk) disable iff (srst) past_valid_r && illegal |-> $stable(result) && $stable(cc);
  endproperty
  a_illegal_hold: assert property (p_illegal_hold) else $error("illegal opcode changed state");

  property p_done_excl;
    @(posedge clk) disable iff (srst) !(done && illegal);
  endproperty
  a_done_excl: assert property (p_done_excl) else $error("done and illegal together");

  c_shl: cover property (@(posedge clk) disable iff (srst) start && op == OP_SHL ##1 cc[CC_V]);
  c_ror_byte: cover property (@(posedge clk) disable iff (srst) start && op == OP_ROR && byte_mode);
  c_rol_zero: cover property (@(posedge clk) disable iff (srst) start && op == OP_ROL ##1 cc[CC_Z]);
  c_illegal: cover property (@(posedge clk) disable iff (srst) illegal);
endmodule // shift_rotate_unit

/* File: testbench.sv */
// testbench: self-checking bench for the shift/rotate slice, queue of expected results
// assumes the slice answers one cycle after each taken start, in issue order
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import shift_rotate_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic [WORD_W-1:0] instr = WORD_ZERO;
  logic [WORD_W-1:0] operand = WORD_ZERO;
  logic psw_c = 1'b0;
  logic done, illegal;
  logic [WORD_W-1:0] result;
  logic [3:0] cc;
  logic [20:0] exp_q[$];
  logic [19:0] last = 20'h00000;
  logic [8:0] opc_tab[4] = '{OPC_SHIFT_LEFT, OPC_ROTATE_RIGHT, OPC_ROTATE_LEFT, 9'h032};
  int miscompares = 0;
  int num_checks = 0;
  shift_rotate_unit uut (.clk(clk), .srst(srst), .start(start), .instr(instr), .operand(operand),
    .psw_c(psw_c), .done(done), .illegal(illegal), .result(result), .cc(cc));
  always #5 clk = ~clk;
  // reference: op 0 shift left, 1 rotate right, 2 rotate left; returns {result, N, Z, V, C}
  function automatic logic [19:0] model(input int op, input logic b, input logic [15:0] d, input logic c);
    logic [15:0] r;
    logic co, n, z;
    int t;
    t = b ? BYTE_TOP : WORD_TOP;
    r = {d[14:0], 1'b0};
    co = d[t];
    if (op == 1)
    begin
      r = d >> 1;
      r[t] = c;
      co = d[0];
    end
    if (op == 2)
      r = {d[14:0], c};
    if (b)
      r[15:8] = d[15:8];
    n = r[t];
    z = b ? (r[7:0] == 8'h00) : (r == WORD_ZERO);
    return {r, n, z, n ^ co, co};
  endfunction
  task automatic bad(input logic [15:0] a, input logic [15:0] e);
    miscompares++;
    $display("BAD t=%0t got %h exp %h", $time, a, e);
  endtask
  task automatic check_res(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e) bad(a, e);
  endtask
  task automatic check_cc(input logic [3:0] a, input logic [3:0] e);
    num_checks++;
    if (a !== e) bad({12'h000, a}, {12'h000, e});
  endtask
  task automatic check_flag(input logic a, input logic e);
    num_checks++;
    if (a !== e) bad({15'h0000, a}, {15'h0000, e});
  endtask
  // op 3 is an unrecognised opcode: result and flags must stay as they were
  task automatic issue(input int op, input logic b, input logic [15:0] d, input logic c);
    logic [19:0] e;
    e = (op == 3) ? last : model(op, b, d, c);
    if (op != 3) last = e;
    exp_q.push_back({op == 3, e});
    start = 1'b1;
    instr = {b, opc_tab[op], 6'h05};
    operand = d;
    psw_c = c;
    @(negedge clk);
  endtask
  task automatic drain;
    start = 1'b0;
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clk);
    if (exp_q.size() > 0) finish_test_timeout();
  endtask
  task automatic finish_test_timeout;
    miscompares++;
    finish_test();
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (!srst && (done === 1'b1 || illegal === 1'b1))
    begin
      if (exp_q.size() == 0) bad({15'h0000, done}, 16'h0000);
      else
      begin
        check_flag(illegal, exp_q[0][20]);
        check_res(result, exp_q[0][19:4]);
        check_cc(cc, exp_q[0][3:0]);
        void'(exp_q.pop_front());
      end
    end
  end
  initial
  begin
    void'($urandom(32'h6A2D));
    repeat (20) @(negedge clk);
    srst = 1'b0;
    check_res(result, WORD_ZERO);
    check_cc(cc, CC_RESET);
    // boundary values back to back: sign change, all-zero result, carry chain both ways
    issue(0, 1'b0, 16'h4000, 1'b0);
    issue(0, 1'b0, 16'h8000, 1'b1);
    issue(1, 1'b0, 16'h0001, 1'b1);
    issue(2, 1'b0, 16'h8000, 1'b0);
    issue(3, 1'b0, 16'h1234, 1'b1);
    issue(2, 1'b1, 16'hAB80, 1'b0);
    issue(1, 1'b1, 16'h5501, 1'b0);
    issue(0, 1'b1, 16'h0040, 1'b0);
    drain();
    $display("test directed end");
    // random mix with idle gaps; illegal opcodes in between
    for (int i = 0; i < 300; i++)
    begin
      if ($urandom_range(0, 3) == 0)
      begin
        start = 1'b0;
        @(negedge clk);
      end
      issue($urandom_range(0, 3), 1'($urandom), 16'($urandom), 1'($urandom));
    end
    drain();
    $display("test random end");
    finish_test();
  end
endmodule // testbench
